// file: core/pwrc_pkg.sv
// Package with register map, field positions and codes of the timer run control block
package pwrc_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_STROBES  = 8'h26;
  localparam logic [7:0] IDX_CLK_RUN  = 8'h2C;
  localparam logic [7:0] IDX_SS_SYNC  = 8'h2E;
  localparam int         ADR_WIDTH    = 8;

  // Reset values
  localparam logic [15:0] RST_CLK_RUN = 16'h0000;
  localparam logic [15:0] RST_SS_SYNC = 16'h0000;

  // Clock and run control fields
  localparam int F_MAIN_CLK_LO  = 0;
  localparam int F_MAIN_PRE     = 3;
  localparam int F_MAIN_RUN     = 4;
  localparam int F_MAIN_STE     = 5;
  localparam int F_MAIN_DIR     = 6;
  localparam int F_MAIN_ALIGN   = 7;
  localparam int F_AUX_CLK_LO   = 8;
  localparam int F_AUX_PRE      = 11;
  localparam int F_AUX_RUN      = 12;
  localparam int F_AUX_STE      = 13;

  // Single-shot and synchronisation fields
  localparam int F_MAIN_SS      = 0;
  localparam int F_AUX_SS       = 1;
  localparam int F_TRIG_SEL_LO  = 2;
  localparam int F_TRIG_DIR_LO  = 5;
  localparam int F_MAIN_XR_LO   = 8;
  localparam int F_AUX_XR_LO    = 10;
  localparam logic [15:0] SS_SYNC_MASK = 16'h0F7F;

  // Strobe register fields
  localparam int S_MAIN_RUN_CLR = 0;
  localparam int S_MAIN_RUN_SET = 1;
  localparam int S_MAIN_CNT_RES = 2;
  localparam int S_DT_RES       = 3;
  localparam int S_MAIN_STR     = 6;
  localparam int S_MAIN_STD     = 7;
  localparam int S_AUX_RUN_CLR  = 8;
  localparam int S_AUX_RUN_SET  = 9;
  localparam int S_AUX_CNT_RES  = 10;
  localparam int S_AUX_STR      = 14;
  localparam int S_AUX_STD      = 15;

  // Prescaler
  localparam int  PRESCALE_BITS = 15;
  localparam int  EXTRA_STAGE   = 8;

  // Trigger select codes
  localparam logic [2:0] TRIG_NONE   = 3'h0;
  localparam logic [2:0] TRIG_CH0    = 3'h1;
  localparam logic [2:0] TRIG_CH1    = 3'h2;
  localparam logic [2:0] TRIG_CH2    = 3'h3;
  localparam logic [2:0] TRIG_ANY    = 3'h4;
  localparam logic [2:0] TRIG_PERIOD = 3'h5;
  localparam logic [2:0] TRIG_ZERO   = 3'h6;
  localparam logic [2:0] TRIG_HALL   = 3'h7;

  // Direction qualifier and external run edge codes
  localparam logic [1:0] TDIR_UP     = 2'h1;
  localparam logic [1:0] TDIR_DOWN   = 2'h2;
  localparam logic [1:0] TDIR_ANY    = 2'h3;
  localparam logic [1:0] XR_RISE     = 2'h1;
  localparam logic [1:0] XR_FALL     = 2'h2;
  localparam logic [1:0] XR_BOTH     = 2'h3;

  // Count direction status
  localparam logic DIR_UP   = 1'b0;
  localparam logic DIR_DOWN = 1'b1;

  // Bus answer state
  typedef enum logic [1:0] {
    PWRC_IDLE = 2'b01,
    PWRC_ACK  = 2'b10
  } pwrc_bus_t;
endpackage

// file: core/pwrc_run_control.sv
// Run, clock and shadow control for the main and auxiliary timers
//
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/10ps
// Function
// - Clock select and prescaler writes ignored while that timer runs
// - Main count clock is module clock over two to the select value
// - Main prescaler bit adds a divide-by-256 stage
// - Main timer counts only while its run bit is one
// - Simultaneous set and clear of a run bit leaves it unchanged
// - Main shadow enable lets a shadow event transfer, then clears itself
// - Main shadow event is period match up or one match down
// - Align mode zero wraps upward; one reverses at period and one matches
// - Aux count clock is module clock over two to its select value
// - Aux prescaler bit adds a divide-by-256 stage
// - Aux counts only while run; set or cleared by software and hardware
// - Aux shadow enable lets a period match transfer, then clears itself
// - Reserved control bits read as zero
// - Main single shot stops run and clears channel states at period end
// - Aux single shot stops run and clears compare state at period match
// - Trigger select chooses the main timer event or Hall input edge that starts aux
// - Trigger direction qualifies the trigger by main count direction
// - Trigger direction comes from count direction status
// - Main external run field picks run input edge that sets main run
// - Aux external run field picks run input edge that sets aux run
// - Strobe register reads zero and stores nothing
// - Strobes set and clear run and shadow bits and reset counters
// - Set and clear strobes written together do nothing
// - Counter reset strobe keeps run bit; dead-time reset is separate
module pwrc_run_control (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rstn,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Events from the main counter, qualified by main_count_en
  input  wire logic        main_period_match,
  input  wire logic        main_one_match,
  input  wire logic        main_zero_match,
  input  wire logic [2:0]  main_compare_match,
  // Events from the aux counter, qualified by aux_count_en
  input  wire logic        aux_period_match,
  // Pins
  input  wire logic [2:0]  hall_inputs,
  input  wire logic        main_run_input,
  input  wire logic        aux_run_input,
  // Main timer control
  output logic             main_count_en,
  output logic             main_run_bit,
  output logic             main_count_direction,
  output logic             main_align_mode,
  output logic             main_shadow_transfer,
  output logic             main_counter_reset,
  output logic             channel_state_clear,
  output logic             deadtime_reset,
  // Aux timer control
  output logic             aux_count_en,
  output logic             aux_run_bit,
  output logic             aux_shadow_transfer,
  output logic             aux_counter_reset,
  output logic             aux_state_clear
);

  localparam int PB = pwrc_pkg::PRESCALE_BITS;

  // Mask of low prescaler bits that must all be one for a tick
  function automatic logic [PB-1:0] div_mask(input logic [2:0] sel, input logic pre);
    logic [4:0] n;
    n = {2'b00, sel} + (pre ? 5'(pwrc_pkg::EXTRA_STAGE) : 5'h00);
    div_mask = PB'((16'h0001 << n) - 16'h0001);
  endfunction
  // Run-style flag update: equal set and clear leave the flag as it is
  function automatic logic next_flag(input logic cur, input logic set, input logic clr);
    next_flag = (set == clr) ? cur : set;
  endfunction
  // Edge selection for external run inputs
  function automatic logic edge_pick(input logic [1:0] mode, input logic rise, input logic fall);
    case (mode)
      pwrc_pkg::XR_RISE: edge_pick = rise;
      pwrc_pkg::XR_FALL: edge_pick = fall;
      pwrc_pkg::XR_BOTH: edge_pick = rise | fall;
      default:           edge_pick = 1'b0;
    endcase
  endfunction

  // Control state
  logic [2:0]    main_clock_select, aux_clock_select, aux_trigger_select;
  logic          main_extra_prescale, main_shadow_enable, main_single_shot;
  logic          aux_extra_prescale, aux_shadow_enable, aux_single_shot;
  logic [1:0]    aux_trigger_direction, main_external_run_select, aux_external_run_select;
  logic [PB-1:0] main_prescale, aux_prescale;
  pwrc_pkg::pwrc_bus_t bus_state;
  // Pin synchronisers: 1st stage feeds only the 2nd
  logic [4:0]    pin_s1, pin_s2, pin_s3, pin_filt, pin_rise, pin_fall;
  // Bus decode
  logic          bus_req, wr_commit, hit_strobes, hit_clk_run, hit_ss_sync;
  logic [15:0]   wdata, wmask, strobe, rdata;
  // Hardware events
  logic          main_tick_evt, aux_tick_evt, main_shadow_evt, main_ss_stop, aux_ss_stop;
  logic          trig_hit, trig_dir_ok, aux_trigger, next_main_run, next_aux_run;
  assign bus_req     = wb_cyc_i & wb_stb_i;
  assign wr_commit   = bus_req & wb_we_i & wb_ack_o;
  assign wdata       = wb_dat_i[15:0];
  assign wmask       = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign hit_strobes = (wb_adr_i[7:2] == pwrc_pkg::IDX_STROBES[5:0]);
  assign hit_clk_run = (wb_adr_i[7:2] == pwrc_pkg::IDX_CLK_RUN[5:0]);
  assign hit_ss_sync = (wb_adr_i[7:2] == pwrc_pkg::IDX_SS_SYNC[5:0]);
  // Strobes act once, at the accepting edge, and are never stored
  assign strobe      = (wr_commit && hit_strobes) ? (wdata & wmask) : 16'h0000;
  // Pin synchronisers with agreement filter on the last two stages
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pin_s1   <= 5'h00;
      pin_s2   <= 5'h00;
      pin_s3   <= 5'h00;
      pin_filt <= 5'h00;
    end else begin
      pin_s1   <= {aux_run_input, main_run_input, hall_inputs};
      pin_s2   <= pin_s1;
      pin_s3   <= pin_s2;
      pin_filt <= (pin_s2 & pin_s3) | (pin_filt & (pin_s2 ^ pin_s3));
    end
  end
  // A change counts once the two late stages agree on the new level
  assign pin_rise = pin_s2 & pin_s3 & ~pin_filt;
  assign pin_fall = ~pin_s2 & ~pin_s3 & pin_filt;
  // Match inputs only matter on a count step of their timer
  assign main_tick_evt   = main_count_en;
  assign aux_tick_evt    = aux_count_en;
  assign main_shadow_evt = main_tick_evt &&
                           ((main_period_match && main_count_direction == pwrc_pkg::DIR_UP) ||
                            (main_one_match && main_count_direction == pwrc_pkg::DIR_DOWN));
  // Edge mode stops on period, center mode on one match while down
  assign main_ss_stop    = main_single_shot && main_tick_evt &&
                           (main_align_mode ? (main_one_match &&
                                               main_count_direction == pwrc_pkg::DIR_DOWN)
                                            : main_period_match);
  assign aux_ss_stop     = aux_single_shot && aux_tick_evt && aux_period_match;
  // Trigger source for the aux start
  always_comb begin
    case (aux_trigger_select)
      pwrc_pkg::TRIG_CH0:    trig_hit = main_compare_match[0];
      pwrc_pkg::TRIG_CH1:    trig_hit = main_compare_match[1];
      pwrc_pkg::TRIG_CH2:    trig_hit = main_compare_match[2];
      pwrc_pkg::TRIG_ANY:    trig_hit = |main_compare_match;
      pwrc_pkg::TRIG_PERIOD: trig_hit = main_period_match;
      pwrc_pkg::TRIG_ZERO:   trig_hit = main_zero_match &&
                                        main_count_direction == pwrc_pkg::DIR_UP;
      pwrc_pkg::TRIG_HALL:   trig_hit = |(pin_rise[2:0] | pin_fall[2:0]);
      default:               trig_hit = 1'b0;
    endcase
  end
  // Direction is the status bit, so edge mode only starts with up or any
  always_comb begin
    case (aux_trigger_direction)
      pwrc_pkg::TDIR_UP:   trig_dir_ok = (main_count_direction == pwrc_pkg::DIR_UP);
      pwrc_pkg::TDIR_DOWN: trig_dir_ok = (main_count_direction == pwrc_pkg::DIR_DOWN);
      pwrc_pkg::TDIR_ANY:  trig_dir_ok = 1'b1;
      default:             trig_dir_ok = 1'b0;
    endcase
  end
  // Hall edges are asynchronous; counter events need a count step
  assign aux_trigger = trig_dir_ok &&
                       (aux_trigger_select == pwrc_pkg::TRIG_HALL ? trig_hit
                                                                  : (trig_hit && main_tick_evt));

  // Clock select and prescaler fields, frozen while running
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      main_clock_select   <= pwrc_pkg::RST_CLK_RUN[2:0];
      main_extra_prescale <= 1'b0;
      main_align_mode     <= 1'b0;
      aux_clock_select    <= 3'h0;
      aux_extra_prescale  <= 1'b0;
    end else if (wr_commit && hit_clk_run) begin
      if (!main_run_bit && wb_sel_i[0]) begin
        main_clock_select   <= wdata[pwrc_pkg::F_MAIN_CLK_LO +: 3];
        main_extra_prescale <= wdata[pwrc_pkg::F_MAIN_PRE];
      end
      if (wb_sel_i[0]) begin
        main_align_mode <= wdata[pwrc_pkg::F_MAIN_ALIGN];
      end
      if (!aux_run_bit && wb_sel_i[1]) begin
        aux_clock_select   <= wdata[pwrc_pkg::F_AUX_CLK_LO +: 3];
        aux_extra_prescale <= wdata[pwrc_pkg::F_AUX_PRE];
      end
    end
  end

  // Single-shot and synchronisation register
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      main_single_shot         <= 1'b0;
      aux_single_shot          <= 1'b0;
      aux_trigger_select       <= pwrc_pkg::TRIG_NONE;
      aux_trigger_direction    <= 2'h0;
      main_external_run_select <= 2'h0;
      aux_external_run_select  <= 2'h0;
    end else if (wr_commit && hit_ss_sync) begin
      if (wb_sel_i[0]) begin
        main_single_shot      <= wdata[pwrc_pkg::F_MAIN_SS];
        aux_single_shot       <= wdata[pwrc_pkg::F_AUX_SS];
        aux_trigger_select    <= wdata[pwrc_pkg::F_TRIG_SEL_LO +: 3];
        aux_trigger_direction <= wdata[pwrc_pkg::F_TRIG_DIR_LO +: 2];
      end
      if (wb_sel_i[1]) begin
        main_external_run_select <= wdata[pwrc_pkg::F_MAIN_XR_LO +: 2];
        aux_external_run_select  <= wdata[pwrc_pkg::F_AUX_XR_LO +: 2];
      end
    end
  end
  // Next run levels; the count enables look at them so no step follows a stop
  assign next_main_run = next_flag(main_run_bit, strobe[pwrc_pkg::S_MAIN_RUN_SET] |
    edge_pick(main_external_run_select, pin_rise[3], pin_fall[3]),
    strobe[pwrc_pkg::S_MAIN_RUN_CLR] | main_ss_stop);
  assign next_aux_run  = next_flag(aux_run_bit, strobe[pwrc_pkg::S_AUX_RUN_SET] | aux_trigger |
    edge_pick(aux_external_run_select, pin_rise[4], pin_fall[4]),
    strobe[pwrc_pkg::S_AUX_RUN_CLR] | aux_ss_stop);
  // Run bits: any simultaneous set and clear is a no-op
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      main_run_bit <= 1'b0;
      aux_run_bit  <= 1'b0;
    end else begin
      main_run_bit <= next_main_run;
      aux_run_bit  <= next_aux_run;
    end
  end

  // Shadow enables: a transfer consumes the enable
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      main_shadow_enable <= 1'b0;
      aux_shadow_enable  <= 1'b0;
    end else begin
      main_shadow_enable <= next_flag(main_shadow_enable, strobe[pwrc_pkg::S_MAIN_STR],
                                      strobe[pwrc_pkg::S_MAIN_STD] |
                                      (main_shadow_enable & main_shadow_evt));
      aux_shadow_enable  <= next_flag(aux_shadow_enable, strobe[pwrc_pkg::S_AUX_STR],
                                      strobe[pwrc_pkg::S_AUX_STD] |
                                      (aux_shadow_enable & aux_tick_evt &
                                       aux_period_match));
    end
  end

  // Count direction: edge mode always up, center mode turns at the ends
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      main_count_direction <= pwrc_pkg::DIR_UP;
    end else if (!main_align_mode) begin
      main_count_direction <= pwrc_pkg::DIR_UP;
    end else if (main_tick_evt) begin
      if (main_period_match && main_count_direction == pwrc_pkg::DIR_UP) begin
        main_count_direction <= pwrc_pkg::DIR_DOWN;
      end else if (main_one_match && main_count_direction == pwrc_pkg::DIR_DOWN) begin
        main_count_direction <= pwrc_pkg::DIR_UP;
      end
    end
  end

  // Prescalers are held clear while stopped so the first step is reproducible
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      main_prescale <= '0;
      aux_prescale  <= '0;
    end else begin
      main_prescale <= main_run_bit ? main_prescale + PB'(1) : '0;
      aux_prescale  <= aux_run_bit ? aux_prescale + PB'(1) : '0;
    end
  end

  // Count enables: one-cycle pulses at the selected division
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      main_count_en <= 1'b0;
      aux_count_en  <= 1'b0;
    end else begin
      main_count_en <= main_run_bit && next_main_run &&
                       ((main_prescale & div_mask(main_clock_select, main_extra_prescale)) ==
                        div_mask(main_clock_select, main_extra_prescale));
      aux_count_en  <= aux_run_bit && next_aux_run &&
                       ((aux_prescale & div_mask(aux_clock_select, aux_extra_prescale)) ==
                        div_mask(aux_clock_select, aux_extra_prescale));
    end
  end

  // One-cycle action pulses toward counters and compare logic
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      main_shadow_transfer <= 1'b0;
      aux_shadow_transfer  <= 1'b0;
      main_counter_reset   <= 1'b0;
      aux_counter_reset    <= 1'b0;
      deadtime_reset       <= 1'b0;
      channel_state_clear  <= 1'b0;
      aux_state_clear      <= 1'b0;
    end else begin
      main_shadow_transfer <= main_shadow_enable & main_shadow_evt;
      aux_shadow_transfer  <= aux_shadow_enable & aux_tick_evt & aux_period_match;
      // Counter resets leave the run bits alone, even while running
      main_counter_reset   <= strobe[pwrc_pkg::S_MAIN_CNT_RES];
      aux_counter_reset    <= strobe[pwrc_pkg::S_AUX_CNT_RES];
      deadtime_reset       <= strobe[pwrc_pkg::S_DT_RES];
      channel_state_clear  <= main_ss_stop;
      aux_state_clear      <= aux_ss_stop;
    end
  end

  // Read mux; reserved bits and the strobe register read as zero
  always_comb begin
    rdata = 16'h0000;
    if (hit_clk_run) begin
      rdata[pwrc_pkg::F_MAIN_CLK_LO +: 3] = main_clock_select;
      rdata[pwrc_pkg::F_MAIN_PRE]         = main_extra_prescale;
      rdata[pwrc_pkg::F_MAIN_RUN]         = main_run_bit;
      rdata[pwrc_pkg::F_MAIN_STE]         = main_shadow_enable;
      rdata[pwrc_pkg::F_MAIN_DIR]         = main_count_direction;
      rdata[pwrc_pkg::F_MAIN_ALIGN]       = main_align_mode;
      rdata[pwrc_pkg::F_AUX_CLK_LO +: 3]  = aux_clock_select;
      rdata[pwrc_pkg::F_AUX_PRE]          = aux_extra_prescale;
      rdata[pwrc_pkg::F_AUX_RUN]          = aux_run_bit;
      rdata[pwrc_pkg::F_AUX_STE]          = aux_shadow_enable;
    end else if (hit_ss_sync) begin
      rdata[pwrc_pkg::F_MAIN_SS]             = main_single_shot;
      rdata[pwrc_pkg::F_AUX_SS]              = aux_single_shot;
      rdata[pwrc_pkg::F_TRIG_SEL_LO +: 3]    = aux_trigger_select;
      rdata[pwrc_pkg::F_TRIG_DIR_LO +: 2]    = aux_trigger_direction;
      rdata[pwrc_pkg::F_MAIN_XR_LO +: 2]     = main_external_run_select;
      rdata[pwrc_pkg::F_AUX_XR_LO +: 2]      = aux_external_run_select;
      rdata = rdata & pwrc_pkg::SS_SYNC_MASK;
    end
  end

  // Wishbone answer: ack one cycle after the request, then drop for a cycle
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      bus_state <= pwrc_pkg::PWRC_IDLE;
      wb_ack_o  <= 1'b0;
      wb_dat_o  <= 32'h0000_0000;
    end else begin
      case (bus_state)
        pwrc_pkg::PWRC_IDLE: begin
          if (bus_req) begin
            bus_state <= pwrc_pkg::PWRC_ACK;
            wb_ack_o  <= 1'b1;
            wb_dat_o  <= wb_we_i ? 32'h0000_0000 : {16'h0000, rdata};
          end
        end
        pwrc_pkg::PWRC_ACK: begin
          bus_state <= pwrc_pkg::PWRC_IDLE;
          wb_ack_o  <= 1'b0;
          wb_dat_o  <= 32'h0000_0000;
        end
        default: begin
          bus_state <= pwrc_pkg::PWRC_IDLE;
          wb_ack_o  <= 1'b0;
        end
      endcase
    end
  end

endmodule

// file: testbench/pwrc_run_control_sva.sv
// Checker of bus answers and timer control outputs
`timescale 1ns/10ps
module pwrc_run_control_chk (
  // Clock, reset and bus
  input wire logic        core_clk,
  input wire logic        rstn,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Counter events
  input wire logic        main_period_match,
  input wire logic        main_one_match,
  input wire logic        aux_period_match,
  // Timer controls
  input wire logic        main_count_en,
  input wire logic        main_run_bit,
  input wire logic        main_count_direction,
  input wire logic        main_align_mode,
  input wire logic        main_shadow_transfer,
  input wire logic        aux_count_en,
  input wire logic        aux_run_bit,
  input wire logic        aux_shadow_transfer
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // Request still waiting for its answer
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  // Center-mode count steps that must turn the direction round
  sequence s_top;
    main_count_en && main_period_match && main_align_mode && main_count_direction == 1'b0;
  endsequence
  sequence s_bottom;
    main_count_en && main_one_match && main_align_mode && main_count_direction == 1'b1;
  endsequence
  chk_ack_pulse: assert property (s_req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("request not answered by one ack pulse");
  chk_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h00000000)
    else $error("read data not zero outside ack");
  chk_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
    else $error("upper read data not zero");
  chk_main_step: assert property (main_count_en |-> main_run_bit && $past(main_run_bit))
    else $error("main count step while stopped");
  chk_aux_step: assert property (aux_count_en |-> aux_run_bit && $past(aux_run_bit))
    else $error("aux count step while stopped");
  chk_edge_up: assert property (!main_align_mode [*2] |-> main_count_direction == 1'b0)
    else $error("edge mode not counting up");
  chk_turn_down: assert property (s_top |=> main_count_direction == 1'b1)
    else $error("no turn down at period match");
  chk_turn_up: assert property (s_bottom |=> main_count_direction == 1'b0)
    else $error("no turn up at one match");
  chk_main_shadow: assert property (main_shadow_transfer |-> $past(main_count_en &&
    (main_period_match && !main_count_direction || main_one_match && main_count_direction)))
    else $error("main shadow transfer without event");
  chk_aux_shadow: assert property (aux_shadow_transfer |->
    $past(aux_count_en && aux_period_match))
    else $error("aux shadow transfer without period match");
endmodule
bind pwrc_run_control pwrc_run_control_chk i_pwrc_run_control_chk (.*);

// file: testbench/pwrc_run_control_tb.sv
// Self-checking bench of the timer run control block
`timescale 1ns/10ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
  $display("wrong value %s expected %0h seen %0h", n, e, g); end end
module pwrc_run_control_tb;
  localparam logic [7:0] A_ST = 8'h98, A_CR = 8'hB0, A_SS = 8'hB8;
  logic core_clk = 0, rstn = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o;
  logic [7:0] wb_adr_i = 0;
  logic [3:0] wb_sel_i = 0;
  logic [31:0] wb_dat_i = 0, wb_dat_o;
  logic main_period_match = 0, main_one_match = 0, main_zero_match = 0, aux_period_match = 0;
  logic [2:0] main_compare_match = 0, hall_inputs = 0;
  logic main_run_input = 0, aux_run_input = 0, hall_on = 0;
  logic main_count_en, main_run_bit, main_count_direction, main_align_mode, main_counter_reset;
  logic main_shadow_transfer, channel_state_clear, deadtime_reset, aux_count_en, aux_run_bit;
  logic aux_shadow_transfer, aux_counter_reset, aux_state_clear;
  logic [15:0] rd, v;
  logic [7:0] adrs [4] = '{8'h98, 8'hB0, 8'hB8, 8'h40};
  int num_errors = 0, checks_done = 0, cycles = 0, nr = 0, ns = 0, p;
  int seed = 32'h327C1539;
  pwrc_run_control i_pwrc_run_control (.*);
  // Free-running 200 MHz clock
  always #2.5 core_clk = ~core_clk;
  // Watchdog and pulse tallies; weights keep each pulse kind apart in one sum
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 50000) begin
      num_errors++;
      final_report();
    end
    if (rstn) nr += main_counter_reset + 4 * deadtime_reset + 16 * aux_counter_reset
      + 64 * channel_state_clear + 256 * aux_state_clear;
    if (rstn) ns += main_shadow_transfer + 4 * aux_shadow_transfer;
    if (hall_on && cycles % 8 == 0) hall_inputs <= ~hall_inputs;
  end
  function automatic int div(input logic [2:0] n, input logic pre);
    return 1 << (n + 8 * pre);
  endfunction
  function automatic logic trig(input logic [4:0] c);
    return c[2:0] != 3'h0 && (c[4:3] == pwrc_pkg::TDIR_UP || c[4:3] == pwrc_pkg::TDIR_ANY);
  endfunction
  // One classic cycle; read data is taken at the edge where ack is seen
  task automatic wb(input logic [7:0] a, input logic w, input logic [15:0] d);
    wb_adr_i <= a;
    wb_we_i <= w;
    wb_dat_i <= {16'h0000, d};
    wb_sel_i <= 4'h3;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    @(posedge core_clk);
    while (wb_ack_o !== 1'b1) @(posedge core_clk);
    rd = wb_dat_o[15:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge core_clk);
  endtask
  // Cycles between two count steps of one timer
  task automatic period(input logic aux, output int c);
    c = 0;
    while ((aux ? aux_count_en : main_count_en) !== 1'b1) @(posedge core_clk);
    do begin
      c++;
      @(posedge core_clk);
    end while ((aux ? aux_count_en : main_count_en) !== 1'b1);
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    foreach (adrs[i]) begin
      wb(adrs[i], 1'b0, 16'h0000);
      `CHK("reset value", 16'h0000, rd)
    end
    repeat (4) begin
      v = 16'($random(seed));
      wb(A_SS, 1'b1, v);
      wb(A_SS, 1'b0, 16'h0000);
      `CHK("ss_sync", v & pwrc_pkg::SS_SYNC_MASK, rd)
      wb(A_CR, 1'b1, v);
      wb(A_CR, 1'b0, 16'h0000);
      `CHK("clk_run", v & 16'h0F8F, rd)
    end
    wb(A_SS, 1'b1, 16'h0000);
    // First pass uses the extra stage, later passes random power-of-two selects
    for (int i = 0; i < 3; i++) begin
      wb(A_ST, 1'b1, 16'h0101);
      v = {4'h0, i == 0, 3'($unsigned($random(seed)) % 6),
           4'h0, i == 0, 3'($unsigned($random(seed)) % 6)};
      wb(A_CR, 1'b1, v);
      wb(A_ST, 1'b1, 16'h0202);
      `CHK("runs set", 2'b11, {main_run_bit, aux_run_bit})
      period(1'b0, p);
      `CHK("main division", div(v[2:0], v[3]), p)
      period(1'b1, p);
      `CHK("aux division", div(v[10:8], v[11]), p)
      wb(A_CR, 1'b1, v ^ 16'h0F0F);
      wb(A_CR, 1'b0, 16'h0000);
      `CHK("locked clock", v | 16'h1010, rd)
    end
    wb(A_ST, 1'b1, 16'h0303);
    `CHK("runs kept", 2'b11, {main_run_bit, aux_run_bit})
    wb(A_ST, 1'b1, 16'h040C);
    repeat (3) @(posedge core_clk);
    `CHK("reset pulses", 21, nr)
    wb(A_ST, 1'b0, 16'h0000);
    `CHK("strobe read", 16'h0000, rd)
    wb(A_ST, 1'b1, 16'h4040);
    wb(A_CR, 1'b0, 16'h0000);
    `CHK("enables set", 4'hF, {rd[13:12], rd[5:4]})
    main_period_match <= 1'b1;
    aux_period_match <= 1'b1;
    repeat (80) @(posedge core_clk);
    wb(A_CR, 1'b0, 16'h0000);
    `CHK("enables cleared", 2'b00, {rd[13], rd[5]})
    `CHK("transfers", 5, ns)
    main_compare_match <= 3'h7;
    main_zero_match <= 1'b1;
    hall_on = 1'b1;
    // Every trigger code with every direction code; aux is stopped with no trigger armed
    for (int c = 0; c < 32; c++) begin
      wb(A_SS, 1'b1, 16'h0000);
      wb(A_ST, 1'b1, 16'h0100);
      wb(A_SS, 1'b1, 16'(c << 2));
      repeat (60) @(posedge core_clk);
      `CHK("aux trigger", trig(5'(c)), aux_run_bit)
    end
    hall_on = 1'b0;
    wb(A_SS, 1'b1, 16'h0003);
    repeat (80) @(posedge core_clk);
    `CHK("single shot", 2'b00, {main_run_bit, aux_run_bit})
    `CHK("state clears", 341, nr)
    for (int c = 0; c < 4; c++) begin
      wb(A_SS, 1'b1, 16'(c * 16'h0500));
      wb(A_ST, 1'b1, 16'h0101);
      main_run_input <= 1'b1;
      aux_run_input <= 1'b1;
      repeat (8) @(posedge core_clk);
      `CHK("rise start", {2{c[0]}}, {main_run_bit, aux_run_bit})
      wb(A_ST, 1'b1, 16'h0101);
      main_run_input <= 1'b0;
      aux_run_input <= 1'b0;
      repeat (8) @(posedge core_clk);
      `CHK("fall start", {2{c[1]}}, {main_run_bit, aux_run_bit})
    end
    wb(A_CR, 1'b1, 16'h0080);
    repeat (40) @(posedge core_clk);
    main_period_match <= 1'b0;
    wb(A_CR, 1'b0, 16'h0000);
    `CHK("down status", 1'b1, rd[6])
    wb(A_ST, 1'b1, 16'h0040);
    main_one_match <= 1'b1;
    repeat (40) @(posedge core_clk);
    `CHK("up again", 1'b0, main_count_direction)
    `CHK("one match transfer", 6, ns)
    final_report();
  end
endmodule
